// ### tasch_top.v
// telemetry adc scheduler with config register and rolling averages
`timescale 1ns/1ps
`include "tasch_map.vh"
module tasch_top
(
  input  wire        clk,          // 20 MHz clock
  input  wire        sys_rst,      // synchronous reset, active high
  input  wire [47:0] nvm_cfg,      // configuration restored from eeprom
  input  wire        cfg_wr,       // one-cycle block write strobe
  input  wire [47:0] cfg_wdata,    // six-byte block write data
  input  wire        cfg_rd,       // one-cycle block read strobe
  output reg  [47:0] cfg_rdata,    // six-byte block read data
  output reg         cfg_rd_vld,   // read data valid pulse
  output reg         cfg_wr_rej,   // write rejected pulse
  input  wire [1:0]  tel_rd_sel,   // channel of telemetry read
  input  wire        tel_rd,       // one-cycle telemetry read strobe
  output reg  [15:0] tel_rdata,    // averaged telemetry value
  output reg         tel_rd_vld,   // telemetry read valid pulse
  output reg         adc_start,    // start conversion pulse
  output reg  [1:0]  adc_chan,     // channel being converted
  input  wire        adc_done,     // conversion done pulse
  input  wire [15:0] adc_data      // conversion result
);

  // ****************************************************************
  // configuration register
  // ****************************************************************
  reg [47:0] cfg_q;
  reg        loaded_q;

  // an averaging code above five is refused
  function avg_ok;
    input [2:0] a;
    begin
      avg_ok = (a <= `TASCH_AVG_MAX);
    end
  endfunction

  function valid_cfg;
    input [47:0] c;
    begin
      valid_cfg = avg_ok(c[26:24]) && avg_ok(c[18:16]) &&
                  avg_ok(c[10:8]) && avg_ok(c[2:0]) &&
                  (c[23:22] != `TASCH_PRI_OFF);
    end
  endfunction

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_q      <= 48'h000000000000;
      loaded_q   <= 1'b0;
      cfg_wr_rej <= 1'b0;
    end
    else
    begin
      cfg_wr_rej <= 1'b0;
      if (!loaded_q)
      begin
        loaded_q <= 1'b1;
        cfg_q    <= {`TASCH_TOP_BYTE, nvm_cfg[39:0]};
      end
      else if (cfg_wr)
      begin
        if (valid_cfg(cfg_wdata))
          cfg_q <= {`TASCH_TOP_BYTE, cfg_wdata[39:0]};
        else
          cfg_wr_rej <= 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_rdata  <= 48'h000000000000;
      cfg_rd_vld <= 1'b0;
    end
    else
    begin
      cfg_rd_vld <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= cfg_q;
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  function [1:0] pri_of;
    input [47:0] c;
    input [1:0]  ch;
    begin
      case (ch)
        `TASCH_CH_VOUT: pri_of = c[7:6];
        `TASCH_CH_IOUT: pri_of = c[15:14];
        `TASCH_CH_TEMP: pri_of = (c[23:22] == `TASCH_PRI_OFF) ? `TASCH_PRI_A : c[23:22];
        default:        pri_of = c[31:30];
      endcase
    end
  endfunction

  function [2:0] avg_of;
    input [47:0] c;
    input [1:0]  ch;
    begin
      case (ch)
        `TASCH_CH_VOUT: avg_of = c[2:0];
        `TASCH_CH_IOUT: avg_of = c[10:8];
        `TASCH_CH_TEMP: avg_of = c[18:16];
        default:        avg_of = c[26:24];
      endcase
    end
  endfunction

  // next channel of a class after a given one, cyclic; found flag in bit 2
  function [2:0] next_in;
    input [47:0] c;
    input [1:0]  cls;
    input [1:0]  from;
    reg   [1:0]  k;
    reg          hit;
    reg   [1:0]  res;
    integer      i;
    begin
      hit = 1'b0;
      res = from;
      for (i = 1; i <= 4; i = i + 1)
      begin
        k = from + i[1:0];
        if (!hit && pri_of(c, k) == cls)
        begin
          hit = 1'b1;
          res = k;
        end
      end
      next_in = {hit, res};
    end
  endfunction

  // ****************************************************************
  // scheduler
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [2:0] st_q;
  reg [1:0] pa_q, pb_q, pc_q;    // last channel visited in each class
  reg       b_due_q, c_due_q;    // an insertion slot is owed
  reg [1:0] cur_q;
  reg [1:0] pick_cls;            // class of the next conversion
  reg [1:0] pick_ch;             // channel of the next conversion

  wire [2:0] na = next_in(cfg_q, `TASCH_PRI_A, pa_q);
  wire [2:0] nb = next_in(cfg_q, `TASCH_PRI_B, pb_q);
  wire [2:0] nc = next_in(cfg_q, `TASCH_PRI_C, pc_q);
  // the pick after the one about to be made, to see whether it closes a pass
  wire [2:0] na_nx = next_in(cfg_q, `TASCH_PRI_A, na[1:0]);
  wire [2:0] nb_nx = next_in(cfg_q, `TASCH_PRI_B, nb[1:0]);
  // a pick closes its class's pass when the class's following pick wraps
  wire a_last = na_nx[1:0] <= na[1:0];
  wire b_last = nb_nx[1:0] <= nb[1:0];
  // an owed slot is served only if a lower class has a channel at all
  wire slot_go = b_due_q && (nb[2] || nc[2]);
  wire c_go    = c_due_q && nc[2];

  // ****************************************************************
  // next pick: owed slot first, then class a, then what is left
  // ****************************************************************
  always @*
  begin
    pick_cls = `TASCH_PRI_C;
    pick_ch  = nc[1:0];
    if (slot_go)
    begin
      // the slot goes to class c once a class b pass has closed
      if (!c_go && nb[2])
      begin
        pick_cls = `TASCH_PRI_B;
        pick_ch  = nb[1:0];
      end
    end
    else if (na[2])
    begin
      pick_cls = `TASCH_PRI_A;
      pick_ch  = na[1:0];
    end
    else if (nb[2] && !c_go)
    begin
      // no class a channel: class b runs back to back
      pick_cls = `TASCH_PRI_B;
      pick_ch  = nb[1:0];
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q      <= ST_IDLE;
      pa_q      <= 2'h3;
      pb_q      <= 2'h3;
      pc_q      <= 2'h3;
      b_due_q   <= 1'b0;
      c_due_q   <= 1'b0;
      cur_q     <= 2'h0;
      adc_start <= 1'b0;
      adc_chan  <= 2'h0;
    end
    else
    begin
      adc_start <= 1'b0;
      case (st_q)
        ST_IDLE:
          if (loaded_q)
            st_q <= ST_CONV;
        ST_CONV:
        begin
          st_q      <= ST_WAIT;
          adc_start <= 1'b1;
          cur_q     <= pick_ch;
          adc_chan  <= pick_ch;
          case (pick_cls)
            `TASCH_PRI_A:
            begin
              // owe one lower slot when this pick closes the class a pass
              pa_q    <= pick_ch;
              b_due_q <= a_last;
            end
            `TASCH_PRI_B:
            begin
              // owe class c the next slot once the class b pass closes
              pb_q    <= pick_ch;
              b_due_q <= 1'b0;
              c_due_q <= c_due_q | b_last;
            end
            default:
            begin
              pc_q    <= pick_ch;
              b_due_q <= 1'b0;
              c_due_q <= 1'b0;
            end
          endcase
        end
        ST_WAIT:
          if (adc_done)
            st_q <= ST_CONV;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // rolling averages: up to 32 samples per channel
  // ****************************************************************
  reg [15:0] smp_q [0:127];
  reg [4:0]  wp_q  [0:3];
  reg [20:0] sum_q [0:3];
  reg [5:0]  fill_q[0:3];
  reg [2:0]  avg_q [0:3];
  integer    j;

  wire [2:0]  cur_avg = avg_of(cfg_q, cur_q);
  wire [5:0]  depth   = 6'h01 << cur_avg;
  wire [4:0]  old_ix  = wp_q[cur_q] - depth[4:0];
  wire [15:0] old_s   = smp_q[{cur_q, old_ix}];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        wp_q[j]   <= 5'h00;
        sum_q[j]  <= 21'h000000;
        fill_q[j] <= 6'h00;
        avg_q[j]  <= 3'h0;
      end
    end
    else if (st_q == ST_WAIT && adc_done)
    begin
      smp_q[{cur_q, wp_q[cur_q]}] <= adc_data;
      wp_q[cur_q] <= wp_q[cur_q] + 5'h01;
      if (avg_q[cur_q] != cur_avg)                    // depth changed: restart window
      begin
        avg_q[cur_q]  <= cur_avg;
        sum_q[cur_q]  <= {5'h00, adc_data};
        fill_q[cur_q] <= 6'h01;
      end
      else if (fill_q[cur_q] < depth)
      begin
        sum_q[cur_q]  <= sum_q[cur_q] + {5'h00, adc_data};
        fill_q[cur_q] <= fill_q[cur_q] + 6'h01;
      end
      else
        sum_q[cur_q] <= sum_q[cur_q] + {5'h00, adc_data} - {5'h00, old_s};
    end
  end

  // ****************************************************************
  // telemetry read port
  // ****************************************************************
  function [15:0] mean_of;
    input [20:0] s;
    input [5:0]  n;
    begin
      case (n)
        6'h02:   mean_of = s[16:1];
        6'h04:   mean_of = s[17:2];
        6'h08:   mean_of = s[18:3];
        6'h10:   mean_of = s[19:4];
        6'h20:   mean_of = s[20:5];
        default: mean_of = s[15:0];
      endcase
    end
  endfunction

  wire [5:0] rd_n = fill_q[tel_rd_sel];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tel_rdata  <= 16'h0000;
      tel_rd_vld <= 1'b0;
    end
    else
    begin
      tel_rd_vld <= tel_rd;
      if (tel_rd)
      begin
        if (pri_of(cfg_q, tel_rd_sel) == `TASCH_PRI_OFF || rd_n == 6'h00)
          tel_rdata <= 16'h0000;
        else
          tel_rdata <= mean_of(sum_q[tel_rd_sel], rd_n);
      end
    end
  end

endmodule // tasch_top

// ### tasch_map.vh
// constants for the telemetry adc scheduler
// How it works
// - one converter, one channel at a time
// - convert all highest class channels first
// - one middle sample after each top pass, a lowest one instead once a middle pass has closed
// - one lowest sample after each middle pass
// - vin priority codes; 11b disables vin
// - vin average depth is two to N
// - temp priority codes; 11b is invalid
// - temp average depth is two to N
// - iout priority codes; 11b disables iout
// - iout average depth is two to N
// - vout priority codes; 11b disables vout
// - vout average depth is two to N
// - disabled channel reads back as zero
// - temperature can never leave the schedule
// - top config byte reads zero, read-only
// - six-byte block access, on-the-fly, nvm restore
`ifndef TASCH_MAP_VH
`define TASCH_MAP_VH
`define TASCH_CMD_CONFIG   8'hD0
`define TASCH_CFG_BYTES    6
`define TASCH_VIN_PRI_HI   31
`define TASCH_VIN_AVG_LO   24
`define TASCH_TMP_PRI_HI   23
`define TASCH_TMP_AVG_LO   16
`define TASCH_IO_PRI_HI    15
`define TASCH_IO_AVG_LO    8
`define TASCH_VO_PRI_HI    7
`define TASCH_VO_AVG_LO    0
`define TASCH_PRI_A        2'h0
`define TASCH_PRI_B        2'h1
`define TASCH_PRI_C        2'h2
`define TASCH_PRI_OFF      2'h3
`define TASCH_AVG_MAX      3'h5
`define TASCH_TOP_BYTE     8'h00
`define TASCH_CH_VOUT      2'h0
`define TASCH_CH_IOUT      2'h1
`define TASCH_CH_TEMP      2'h2
`define TASCH_CH_VIN       2'h3
`endif

// ### tasch_adc_model.sv
// behavioural converter answering start pulses
`timescale 1ns/1ps
module tasch_adc_model
(
  input  wire        clk,       // clock
  input  wire        adc_start, // start pulse
  input  wire [1:0]  adc_chan,  // channel
  input  wire [3:0]  dly,       // answer delay
  output reg         adc_done,  // done pulse
  output reg  [15:0] adc_data   // result
);
  reg [3:0] cnt_q;
  reg       busy_q;
  initial
  begin
    adc_done = 1'b0;
    adc_data = 16'h0000;
    busy_q   = 1'b0;
    cnt_q    = 4'h0;
  end
  // ****
  // fixed code per channel, data toggles while idle
  // ****
  always @(posedge clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start)
    begin
      busy_q <= 1'b1;
      cnt_q  <= dly;
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q   <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= {8'hA5, 6'h00, adc_chan};
    end
    else if (busy_q)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule // tasch_adc_model

// ### tasch_top_monitor.sv
// port checker for the telemetry adc scheduler
`timescale 1ns/1ps
module tasch_monitor
(
  input wire        clk,        // clock
  input wire        sys_rst,    // reset
  input wire        cfg_wr,     // write strobe
  input wire [47:0] cfg_wdata,  // write data
  input wire        cfg_rd,     // read strobe
  input wire [47:0] cfg_rdata,  // read data
  input wire        cfg_rd_vld, // read valid
  input wire        cfg_wr_rej, // write rejected
  input wire        tel_rd,     // telemetry read
  input wire        tel_rd_vld, // telemetry valid
  input wire        adc_start,  // start pulse
  input wire [1:0]  adc_chan,   // channel
  input wire        adc_done    // done pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // checks
  // ****
  wire bad_wr = (cfg_wdata[23:22] == 2'h3) || (cfg_wdata[26:24] > 3'h5) || (cfg_wdata[18:16] > 3'h5)
    || (cfg_wdata[10:8] > 3'h5) || (cfg_wdata[2:0] > 3'h5);
  sequence s_conv; adc_start ##1 !adc_start; endsequence
  sequence s_restart; adc_done ##1 !adc_start ##1 adc_start; endsequence
  AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rd_vld)
    else $error("read not answered");
  AST_TOP_BYTE: assert property (cfg_rd_vld |-> cfg_rdata[47:40] == 8'h00)
    else $error("top byte not zero");
  AST_REJECT: assert property (cfg_wr && bad_wr |=> cfg_wr_rej)
    else $error("bad write taken");
  AST_ACCEPT: assert property (cfg_wr && !bad_wr |=> !cfg_wr_rej)
    else $error("good write refused");
  AST_TEMP_KEEP: assert property (cfg_wr && cfg_wdata[23:22] == 2'h3 |=> cfg_wr_rej)
    else $error("temp disable taken");
  AST_TEL_ANSWER: assert property (tel_rd |=> tel_rd_vld)
    else $error("telemetry not answered");
  AST_ONE_CONV: assert property (adc_start |=> !adc_start until adc_done)
    else $error("overlapping start");
  AST_NO_IDLE: assert property (adc_done |-> s_restart)
    else $error("converter idled");
  AST_CHAN_HOLD: assert property (s_conv |-> $stable(adc_chan))
    else $error("channel moved");
endmodule // tasch_monitor
bind tasch_top tasch_monitor u_mon (.clk, .sys_rst, .cfg_wr, .cfg_wdata, .cfg_rd, .cfg_rdata, .cfg_rd_vld,
  .cfg_wr_rej, .tel_rd, .tel_rd_vld, .adc_start, .adc_chan, .adc_done);

// ### test_telemetry_adc_scheduler.sv
// self-checking bench for the telemetry adc scheduler
`timescale 1ns/1ps
module test_telemetry_adc_scheduler;
  reg         clk;
  reg         sys_rst;
  reg         cfg_wr;
  reg         cfg_rd;
  reg         tel_rd;
  reg  [1:0]  tel_rd_sel;
  reg  [3:0]  dly;
  reg  [47:0] cfg_wdata;
  wire [47:0] cfg_rdata;
  wire [15:0] tel_rdata;
  wire [15:0] adc_data;
  wire [1:0]  adc_chan;
  wire        cfg_rd_vld;
  wire        cfg_wr_rej;
  wire        tel_rd_vld;
  wire        adc_start;
  wire        adc_done;
  integer     n_mismatch;
  integer     samples_checked;
  tasch_top u_dut (.clk(clk), .sys_rst(sys_rst), .nvm_cfg(48'h5A03_0000_0000), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rd_vld(cfg_rd_vld),
    .cfg_wr_rej(cfg_wr_rej), .tel_rd_sel(tel_rd_sel), .tel_rd(tel_rd), .tel_rdata(tel_rdata),
    .tel_rd_vld(tel_rd_vld), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_data(adc_data));
  tasch_adc_model u_adc (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan), .dly(dly),
    .adc_done(adc_done), .adc_data(adc_data));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task conclude;
  begin
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input [47:0] seen, input [47:0] exp, input [8*6-1:0] what);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
    end
  end
  endtask
  task wr(input [47:0] d, input rej);
  begin
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1 chk(cfg_wr_rej, rej, "reject");
  end
  endtask
  task rd_cfg(input [47:0] exp);
  begin
    @(posedge clk);
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 chk(cfg_rd_vld, 1'b1, "rdvld");
    chk(cfg_rdata, exp, "config");
  end
  endtask
  task pick(output [1:0] ch);
    integer i;
  begin
    i = 0;
    @(posedge clk);
    #1;
    while (adc_start !== 1'b1 && i < 200)
    begin
      @(posedge clk);
      #1;
      i = i + 1;
    end
    if (i == 200)
    begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
    ch = adc_chan;
  end
  endtask
  task order(input [1:0] first, input [15:0] pat);
    reg [1:0] ch;
    integer k;
  begin
    k = 0;
    pick(ch);
    while (ch !== first && k < 8)
    begin
      pick(ch);
      k = k + 1;
    end
    for (k = 0; k < 8; k = k + 1)
    begin
      pick(ch);
      chk(ch, pat[2*k+:2], "chan");
    end
  end
  endtask
  task t_sched;
  begin
    dly = 4'h0;
    wr(48'h0003_0202_0202, 1'b0);
    order(2'h3, 16'hE4E4);
    dly = 4'h6;
    wr(48'h0003_C080_4000, 1'b0);
    order(2'h2, 16'h8484);
    $display("sched done");
  end
  endtask
  task t_reject;
    integer k;
  begin
    rd_cfg(48'h0003_0000_0000);
    wr(48'hFF03_0202_0202, 1'b0);
    rd_cfg(48'h0003_0202_0202);
    wr(48'h0003_02C2_0202, 1'b1);
    for (k = 0; k < 4; k = k + 1)
      wr(48'h0003_0202_0202 | (48'h5 << (8 * k)), 1'b1);
    rd_cfg(48'h0003_0202_0202);
    $display("reject done");
  end
  endtask
  task t_off(input [47:0] cfg, input [3:0] off);
    integer k;
    reg [1:0] ch;
  begin
    dly = 4'h0;
    wr(cfg, 1'b0);
    for (k = 0; k < 110; k = k + 1)
      pick(ch);
    for (k = 0; k < 4; k = k + 1)
    begin
      @(posedge clk);
      tel_rd <= 1'b1;
      tel_rd_sel <= k[1:0];
      @(posedge clk);
      tel_rd <= 1'b0;
      #1 chk(tel_rd_vld, 1'b1, "telvld");
      chk(tel_rdata, off[k] ? 16'h0000 : {8'hA5, 6'h00, k[1:0]}, "tel");
    end
    $display("disable done");
  end
  endtask
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    tel_rd = 1'b0;
    tel_rd_sel = 2'h0;
    dly = 4'h0;
    cfg_wdata = 48'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reject;
    t_sched;
    t_off(48'h0003_C205_0205, 4'h8);
    t_off(48'h0003_0202_C2C2, 4'h3);
    conclude;
  end
endmodule // test_telemetry_adc_scheduler
